/* shared/stc_pkg.sv */
/*
 Shared constants for the scan timer and counter rail.
 Assumes one 250 MHz clock and a scan sequencer that issues a scan tick.
*/
package stc_pkg;
   localparam int          VAL_W         = 16;
   localparam logic [15:0] TIMER_SET_MAX = 16'h7fff;
   localparam logic [15:0] COUNT_SET_MAX = 16'hffff;
   localparam logic [15:0] VAL_ZERO      = 16'h0000;
   localparam int          FAST_LAST     = 63;
   localparam int          FAST_LAST_SM  = 31;
   localparam real         FINE_BASE_S   = 0.01;
   localparam real         COARSE_BASE_S = 0.1;
   localparam real         CLK_PERIOD_S  = 4.0e-9;
   localparam int          FINE_CYC      = int'(FINE_BASE_S / CLK_PERIOD_S);
   localparam int          COARSE_CYC    = int'(COARSE_BASE_S / CLK_PERIOD_S);
endpackage

/* shared/stc_link_if.sv */
/*
 Link between the scan sequencer and the timer bank.
 Assumes both ends share mclk_i; the sequencer drives the scan tick.
*/
`timescale 1ns/1ps
interface stc_link_if #(parameter int N_TMR = 2);
   logic                    scan_tick;
   logic [N_TMR-1:0]        ofd_in;
   logic [N_TMR-1:0]        ss_in;
   logic [N_TMR*16-1:0]     ofd_set;
   logic [N_TMR*16-1:0]     ss_set;
   logic [N_TMR-1:0]        ofd_done;
   logic [N_TMR-1:0]        ss_done;
   logic [N_TMR*16-1:0]     ofd_val;
   logic [N_TMR*16-1:0]     ss_val;
   logic                    cnt_in;
   logic                    cnt_en;
   logic [15:0]             cnt_set;
   logic                    cnt_done;
   logic [15:0]             cnt_val;
   logic                    rail_gate_set;
   logic                    rail_gate_reset;
   logic                    rail_on;
   logic                    edge_src;
   logic                    edge_pulse;
   modport dev (input scan_tick, ofd_in, ss_in, ofd_set, ss_set, cnt_in, cnt_en, cnt_set,
                rail_gate_set, rail_gate_reset, edge_src,
                output ofd_done, ss_done, ofd_val, ss_val, cnt_done, cnt_val, rail_on,
                edge_pulse);
   modport seq (output scan_tick, ofd_in, ss_in, ofd_set, ss_set, cnt_in, cnt_en, cnt_set,
                rail_gate_set, rail_gate_reset, edge_src,
                input ofd_done, ss_done, ofd_val, ss_val, cnt_done, cnt_val, rail_on,
                edge_pulse);
endinterface

/* src/stc_base_tick.sv */
/*
 Time-base generator: pulses one cycle every PERIOD clocks.
 Assumes a free-running mclk_i.
*/
`timescale 1ns/1ps
module stc_base_tick #(
   parameter int PERIOD = stc_pkg::FINE_CYC
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   logic [31:0] cnt_reg;
   wire         wrap = (cnt_reg == 32'(PERIOD - 1));
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= 32'h0000_0000;
         tick_o  <= 1'b0;
      end else begin
         cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
         tick_o  <= wrap;
      end
   end
endmodule

/* src/stc_device.sv */
/*
 Timer and counter bank: off-delay and single-shot timers, an enabled
 event counter, a rail gate and a positive edge detector.
 Assumes the sequencer drives the link on mclk_i and pulses scan_tick once per scan.
*/
`timescale 1ns/1ps
module stc_device #(
   parameter int N_TMR      = 2,
   parameter int FINE_CYC   = stc_pkg::FINE_CYC,
   parameter int COARSE_CYC = stc_pkg::COARSE_CYC,
   parameter bit SMALL_VAR  = 1'b0,
   parameter int FIRST_NUM  = 62
) (
   input  wire logic  mclk_i,
   input  wire logic  rst_i,
   input  wire logic  power_ok_i,
   input  wire logic  [2*N_TMR-1:0] retain_i,
   stc_link_if.dev    lnk
);
   logic fine_tick;
   logic coarse_tick;
   logic fine_seen_reg;
   logic coarse_seen_reg;

   // Time bases run apart from the scan; a base tick is latched until the next scan.
   stc_base_tick #(.PERIOD(FINE_CYC))   u_fine   (.mclk_i(mclk_i), .rst_i(rst_i),
                                                  .tick_o(fine_tick));
   stc_base_tick #(.PERIOD(COARSE_CYC)) u_coarse (.mclk_i(mclk_i), .rst_i(rst_i),
                                                  .tick_o(coarse_tick));

   wire scan = lnk.scan_tick;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         fine_seen_reg   <= 1'b0;
         coarse_seen_reg <= 1'b0;
      end else begin
         fine_seen_reg   <= fine_tick | (fine_seen_reg & ~scan);
         coarse_seen_reg <= coarse_tick | (coarse_seen_reg & ~scan);
      end
   end

   function automatic logic fine_base(input int num);
      fine_base = SMALL_VAR ? (num <= stc_pkg::FAST_LAST_SM)
                            : (num <= stc_pkg::FAST_LAST);
   endfunction

   function automatic logic [15:0] clip_set(input logic [15:0] s);
      clip_set = (s > stc_pkg::TIMER_SET_MAX) ? stc_pkg::TIMER_SET_MAX : s;
   endfunction

   // The rail is sampled once per scan like the timer and counter state, so every done output (not the edge pulse) between
   // the set and reset points switches on the same edge as the timers behind it.
   wire  gate_open = lnk.rail_gate_set;
   logic rail_reg;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rail_reg <= 1'b0;
      end else if (scan) begin
         rail_reg <= gate_open;
      end
   end
   assign lnk.rail_on = rail_reg;

   genvar g;
   generate
      for (g = 0; g < N_TMR; g++) begin : g_tmr
         logic [15:0] ofd_val_reg;
         logic [15:0] ofd_val_next;
         logic        ofd_done_reg;
         logic        ofd_done_next;
         logic        ofd_out_reg;
         logic [15:0] ss_val_reg;
         logic [15:0] ss_val_next;
         logic        ss_on_reg;
         logic        ss_on_next;
         logic        ss_prev_reg;
         logic        ss_out_reg;
         wire         ofd_in   = lnk.ofd_in[g];
         wire         ss_in    = lnk.ss_in[g];
         wire  [15:0] ofd_set  = clip_set(lnk.ofd_set[g*16 +: 16]);
         wire  [15:0] ss_set   = clip_set(lnk.ss_set[g*16 +: 16]);
         wire         tb_ofd   = fine_base(FIRST_NUM + 2*g)
                                 ? fine_seen_reg : coarse_seen_reg;
         wire         tb_ss    = fine_base(FIRST_NUM + 2*g + 1)
                                 ? fine_seen_reg : coarse_seen_reg;
         wire         ofd_keep = retain_i[2*g] & ~power_ok_i;
         wire         ss_keep  = retain_i[2*g+1] & ~power_ok_i;
         wire         ss_rise  = ss_in & ~ss_prev_reg;
         wire  [15:0] ofd_inc  = ofd_val_reg + 16'h0001;
         wire  [15:0] ss_inc   = ss_val_reg + 16'h0001;
         wire         ofd_up   = (ofd_val_reg >= ofd_set);
         wire         ss_up    = (ss_val_reg >= ss_set);
         wire         ss_start = ss_rise & ~ss_on_reg & (ss_val_reg == stc_pkg::VAL_ZERO);
         // A frozen timer still shows its retained output bit, gated by the rail.
         wire         ofd_show = ofd_keep ? ofd_done_reg : ofd_done_next;
         wire         ss_show  = ss_keep ? ss_on_reg : ss_on_next;

         // The off-delay output only ever falls while the input is off, so a timer
         // that was never switched on cannot turn itself on by counting.
         always_comb begin
            ofd_val_next  = ofd_val_reg;
            ofd_done_next = ofd_done_reg;
            if (ofd_in) begin
               ofd_val_next  = stc_pkg::VAL_ZERO;
               ofd_done_next = 1'b1;
            end else if (ofd_up) begin
               ofd_done_next = 1'b0;
            end else if (tb_ofd) begin
               ofd_val_next  = ofd_inc;
               ofd_done_next = ofd_done_reg & (ofd_inc < ofd_set);
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               ofd_val_reg  <= stc_pkg::VAL_ZERO;
               ofd_done_reg <= 1'b0;
               ofd_out_reg  <= 1'b0;
            end else if (scan) begin
               ofd_out_reg <= ofd_show & gate_open;
               if (!ofd_keep) begin
                  ofd_val_reg  <= ofd_val_next;
                  ofd_done_reg <= ofd_done_next;
               end
            end
         end

         always_comb begin
            ss_val_next = ss_val_reg;
            ss_on_next  = ss_on_reg;
            if (ss_start) begin
               ss_on_next = (ss_set != stc_pkg::VAL_ZERO);
            end else if (ss_on_reg) begin
               if (ss_up) begin
                  ss_on_next = 1'b0;
               end else if (tb_ss) begin
                  ss_val_next = ss_inc;
                  ss_on_next  = (ss_inc < ss_set);
               end
            end else if (!ss_in) begin
               ss_val_next = stc_pkg::VAL_ZERO;
            end
         end

         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               ss_val_reg  <= stc_pkg::VAL_ZERO;
               ss_on_reg   <= 1'b0;
               ss_prev_reg <= 1'b0;
               ss_out_reg  <= 1'b0;
            end else if (scan) begin
               ss_out_reg <= ss_show & gate_open;
               if (!ss_keep) begin
                  ss_prev_reg <= ss_in;
                  ss_val_reg  <= ss_val_next;
                  ss_on_reg   <= ss_on_next;
               end
            end
         end

         assign lnk.ofd_done[g]         = ofd_out_reg;
         assign lnk.ss_done[g]          = ss_out_reg;
         assign lnk.ofd_val[g*16 +: 16] = ofd_val_reg;
         assign lnk.ss_val[g*16 +: 16]  = ss_val_reg;
      end
   endgenerate

   logic [15:0] cnt_val_reg;
   logic [15:0] cnt_val_next;
   logic        cnt_done_reg;
   logic        cnt_prev_reg;
   logic        edge_prev_reg;
   logic        edge_reg;
   wire         cnt_rise  = lnk.cnt_in & ~cnt_prev_reg;
   wire         cnt_full  = (cnt_val_reg >= lnk.cnt_set);
   wire         cnt_step  = lnk.cnt_en & cnt_rise & ~cnt_full;
   wire         edge_next = lnk.edge_src & ~edge_prev_reg;
   wire         cnt_done_next = lnk.cnt_en & (cnt_val_next >= lnk.cnt_set) & gate_open;

   // A disabled counter clears at once; an enabled one saturates at the set value.
   always_comb begin
      cnt_val_next = cnt_val_reg;
      if (!lnk.cnt_en) begin
         cnt_val_next = stc_pkg::VAL_ZERO;
      end else if (cnt_step) begin
         cnt_val_next = cnt_val_reg + 16'h0001;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_val_reg   <= stc_pkg::VAL_ZERO;
         cnt_done_reg  <= 1'b0;
         cnt_prev_reg  <= 1'b0;
         edge_prev_reg <= 1'b0;
         edge_reg      <= 1'b0;
      end else if (scan) begin
         cnt_val_reg   <= cnt_val_next;
         cnt_done_reg  <= cnt_done_next;
         cnt_prev_reg  <= lnk.cnt_in;
         edge_prev_reg <= lnk.edge_src;
         edge_reg      <= edge_next;
      end
   end

   assign lnk.cnt_val    = cnt_val_reg;
   assign lnk.cnt_done   = cnt_done_reg;
   assign lnk.edge_pulse = edge_reg;
endmodule

/* src/stc_sequencer.sv */
/*
 Scan sequencer end: issues scan ticks and forwards user inputs and set values.
 Assumes user inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ps
module stc_sequencer #(
   parameter int N_TMR    = 2,
   parameter int SCAN_CYC = 16
) (
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   input  wire logic [N_TMR-1:0]    ofd_in_i,
   input  wire logic [N_TMR-1:0]    ss_in_i,
   input  wire logic [N_TMR*16-1:0] ofd_set_i,
   input  wire logic [N_TMR*16-1:0] ss_set_i,
   input  wire logic                cnt_in_i,
   input  wire logic                cnt_en_i,
   input  wire logic [15:0]         cnt_set_i,
   input  wire logic                gate_i,
   input  wire logic                edge_src_i,
   output logic [N_TMR-1:0]         ofd_done_o,
   output logic [N_TMR-1:0]         ss_done_o,
   output logic                     cnt_done_o,
   output logic [15:0]              cnt_val_o,
   output logic                     edge_pulse_o,
   stc_link_if.seq                  lnk
);
   logic [31:0] scan_reg;
   logic        tick_reg;
   wire         wrap = (scan_reg == 32'(SCAN_CYC - 1));

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         scan_reg <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end else begin
         scan_reg <= wrap ? 32'h0000_0000 : scan_reg + 32'h0000_0001;
         tick_reg <= wrap;
      end
   end

   // Set values are sent as given; the device clips timers to their legal range.
   assign lnk.scan_tick       = tick_reg;
   assign lnk.ofd_in          = ofd_in_i;
   assign lnk.ss_in           = ss_in_i;
   assign lnk.ofd_set         = ofd_set_i;
   assign lnk.ss_set          = ss_set_i;
   assign lnk.cnt_in          = cnt_in_i;
   assign lnk.cnt_en          = cnt_en_i;
   assign lnk.cnt_set         = cnt_set_i;
   assign lnk.rail_gate_set   = gate_i;
   assign lnk.rail_gate_reset = 1'b1;
   assign lnk.edge_src        = edge_src_i;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ofd_done_o   <= '0;
         ss_done_o    <= '0;
         cnt_done_o   <= 1'b0;
         cnt_val_o    <= 16'h0000;
         edge_pulse_o <= 1'b0;
      end else begin
         ofd_done_o   <= lnk.ofd_done;
         ss_done_o    <= lnk.ss_done;
         cnt_done_o   <= lnk.cnt_done;
         cnt_val_o    <= lnk.cnt_val;
         edge_pulse_o <= lnk.edge_pulse;
      end
   end
endmodule

/* verification/stc_link_properties.sv */
/*
 Concurrent checks on the link between the scan sequencer and the timer bank.
 Assumes two timers per kind, one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module stc_link_props (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        scan_tick,
   input  wire logic [1:0]  ofd_in,
   input  wire logic [1:0]  ss_in,
   input  wire logic [31:0] ofd_set,
   input  wire logic [31:0] ss_set,
   input  wire logic [1:0]  ofd_done,
   input  wire logic [1:0]  ss_done,
   input  wire logic [31:0] ofd_val,
   input  wire logic [31:0] ss_val,
   input  wire logic        cnt_in,
   input  wire logic        cnt_en,
   input  wire logic [15:0] cnt_set,
   input  wire logic        cnt_done,
   input  wire logic [15:0] cnt_val,
   input  wire logic        rail_gate_set,
   input  wire logic        rail_on,
   input  wire logic        edge_src,
   input  wire logic        edge_pulse
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic prev_cnt, prev_ofd, prev_edge, pulse_exp;
   // Inputs as seen at the previous scan, since edges are judged scan to scan.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         {prev_cnt, prev_ofd, prev_edge, pulse_exp} <= 4'h0;
      end else if (scan_tick) begin
         {prev_cnt, prev_ofd, prev_edge} <= {cnt_in, ofd_in[0], edge_src};
         pulse_exp <= edge_src & ~prev_edge;
      end
   end
   no_tick_hold_a: assert property (!scan_tick |=> $stable(cnt_val) && $stable(ofd_val)
      && $stable(ss_val) && $stable(rail_on) && $stable(ofd_done) && $stable(ss_done)
      && $stable(cnt_done)) else $error("value moved without a scan tick");
   cnt_step_a: assert property (scan_tick && cnt_en && cnt_in && !prev_cnt && cnt_val < cnt_set
      |=> cnt_val == $past(cnt_val) + 16'h0001) else $error("counter missed an edge");
   cnt_sat_a: assert property (scan_tick && cnt_en && cnt_val >= cnt_set |=> $stable(cnt_val))
      else $error("counter moved past set value");
   cnt_clear_a: assert property (scan_tick && !cnt_en |=> cnt_val == 16'h0000 && !cnt_done)
      else $error("disabled counter not cleared");
   ofd_rise_a: assert property (scan_tick && ofd_in[0] && !prev_ofd
      |=> ofd_val[15:0] == 16'h0000 && (ofd_done[0] || !rail_on)) else $error("off delay not on");
   ofd_hold_a: assert property (scan_tick && !ofd_in[0] && ofd_val[15:0] >= ofd_set[15:0]
      |=> $stable(ofd_val[15:0]) && !ofd_done[0]) else $error("off delay not held off");
   ss_keep_a: assert property (scan_tick && ss_done[0] && ss_val[15:0] + 16'h0001 < ss_set[15:0]
      |=> ss_done[0] || !rail_on) else $error("single shot dropped early");
   ss_clear_a: assert property (scan_tick && !ss_in[0] && ss_val[15:0] >= ss_set[15:0]
      |=> ss_val[15:0] == 16'h0000) else $error("single shot value not cleared");
   edge_once_a: assert property (edge_pulse == pulse_exp)
      else $error("edge pulse wrong");
   rail_off_a: assert property (!rail_on |-> !ofd_done && !ss_done && !cnt_done)
      else $error("output on with rail off");
   rail_follow_a: assert property (scan_tick |=> rail_on == $past(rail_gate_set))
      else $error("rail does not follow gate");
endmodule

/* verification/tb_top.sv */
/*
 Self-checking bench joining the sequencer and the timer bank over the link.
 Assumes fine and coarse bases shortened to 4 and 40 clocks, and 16-clock scans.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int SCAN = 16;
   logic        mclk_i = 1'b0, rst_i = 1'b1, power_ok = 1'b1, cnt_in = 1'b0, cnt_en = 1'b0;
   logic        gate = 1'b1, edge_src = 1'b0, cnt_done, edge_pulse;
   logic [3:0]  retain = 4'h4;
   logic [1:0]  ofd_in = 2'h0, ss_in = 2'h0, ofd_done, ss_done;
   logic [31:0] ofd_set = 32'h0, ss_set = 32'h0;
   logic [15:0] cnt_set = 16'h0000, cnt_val, last_cv = 16'h0000, v;
   logic [15:0] exp_q[$];
   int          mismatches = 0, tests_run = 0, pulses = 0, n;
   always #2 mclk_i = ~mclk_i;
   stc_link_if i_stc_link_if ();
   stc_sequencer #(.N_TMR(2), .SCAN_CYC(SCAN)) i_stc_sequencer (.mclk_i(mclk_i), .rst_i(rst_i),
      .ofd_in_i(ofd_in), .ss_in_i(ss_in), .ofd_set_i(ofd_set), .ss_set_i(ss_set),
      .cnt_in_i(cnt_in), .cnt_en_i(cnt_en), .cnt_set_i(cnt_set), .gate_i(gate),
      .edge_src_i(edge_src), .ofd_done_o(ofd_done), .ss_done_o(ss_done), .cnt_done_o(cnt_done),
      .cnt_val_o(cnt_val), .edge_pulse_o(edge_pulse), .lnk(i_stc_link_if));
   stc_device #(.N_TMR(2), .FINE_CYC(4), .COARSE_CYC(40)) i_stc_device (.mclk_i(mclk_i),
      .rst_i(rst_i), .power_ok_i(power_ok), .retain_i(retain), .lnk(i_stc_link_if));
   stc_link_props i_stc_link_props (.mclk_i(mclk_i), .rst_i(rst_i),
      .scan_tick(i_stc_link_if.scan_tick), .ofd_in(i_stc_link_if.ofd_in),
      .ss_in(i_stc_link_if.ss_in), .ofd_set(i_stc_link_if.ofd_set),
      .ss_set(i_stc_link_if.ss_set), .ofd_done(i_stc_link_if.ofd_done),
      .ss_done(i_stc_link_if.ss_done), .ofd_val(i_stc_link_if.ofd_val),
      .ss_val(i_stc_link_if.ss_val), .cnt_in(i_stc_link_if.cnt_in),
      .cnt_en(i_stc_link_if.cnt_en), .cnt_set(i_stc_link_if.cnt_set),
      .cnt_done(i_stc_link_if.cnt_done), .cnt_val(i_stc_link_if.cnt_val),
      .rail_gate_set(i_stc_link_if.rail_gate_set), .rail_on(i_stc_link_if.rail_on),
      .edge_src(i_stc_link_if.edge_src), .edge_pulse(i_stc_link_if.edge_pulse));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Waits for n scan ticks, then lets the registered outputs settle.
   task automatic scans(input int cnt);
      int k, t;
      k = 0;
      for (t = 0; t < 40 * cnt && k < cnt; t++) begin
         @(posedge mclk_i);
         if (i_stc_link_if.scan_tick === 1'b1) k++;
         if (edge_pulse === 1'b1) pulses++;
      end
      if (k < cnt) begin
         chk("scan_tick", k[15:0], cnt[15:0]);
         end_of_test();
      end
      repeat (3) @(posedge mclk_i);
   endtask
   // Each change of the count output consumes the oldest expected count.
   always @(posedge mclk_i) begin
      if (!rst_i && cnt_val !== last_cv) begin
         last_cv = cnt_val;
         if (exp_q.size() == 0) chk("cnt_queue", 16'h0001, 16'h0000);
         else chk("cnt_val", cnt_val, exp_q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'h214e3d60));
      retain <= 4'h4 | (4'($urandom) & 4'hb);
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      scans(1);
      chk("ofd_done_rst", {14'h0000, ofd_done}, 16'h0000);
      ofd_set <= {16'h0400 | (16'($urandom) & 16'h03ff), 16'h0003};
      ofd_in <= 2'h3;
      scans(2);
      chk("ofd_done_on", {14'h0000, ofd_done}, 16'h0003);
      chk("ofd_val_clr", i_stc_link_if.ofd_val[15:0], 16'h0000);
      ofd_in <= 2'h0;
      scans(1);
      chk("ofd_done_wait", {15'h0000, ofd_done[0]}, 16'h0001);
      chk("ofd_val_run", i_stc_link_if.ofd_val[15:0], 16'h0001);
      scans(4);
      chk("ofd_done_off", {15'h0000, ofd_done[0]}, 16'h0000);
      chk("ofd_val_hold", i_stc_link_if.ofd_val[15:0], 16'h0003);
      chk("coarse_slow", {15'h0000, i_stc_link_if.ofd_val[31:16] < 16'h0005}, 16'h0001);
      v = i_stc_link_if.ofd_val[31:16];
      power_ok <= 1'b0;
      scans(4);
      chk("retained_val", i_stc_link_if.ofd_val[31:16], v);
      chk("retained_done", {15'h0000, ofd_done[1]}, 16'h0001);
      power_ok <= 1'b1;
      scans(4);
      chk("coarse_runs", {15'h0000, i_stc_link_if.ofd_val[31:16] > v}, 16'h0001);
      $display("test off_delay finished");
      ss_set <= {16'h0000, 16'h0004};
      ss_in <= 2'h3;
      scans(1);
      ss_in <= 2'h0;
      scans(2);
      chk("ss_done_run", {14'h0000, ss_done}, 16'h0001);
      scans(3);
      chk("ss_done_out", {15'h0000, ss_done[0]}, 16'h0000);
      chk("ss_val_clr", i_stc_link_if.ss_val[15:0], 16'h0000);
      ss_in <= 2'h1;
      scans(7);
      chk("ss_val_hold", i_stc_link_if.ss_val[15:0], 16'h0004);
      ss_in <= 2'h0;
      scans(1);
      chk("ss_val_drop", i_stc_link_if.ss_val[15:0], 16'h0000);
      $display("test single_shot finished");
      n = 3 + ($urandom % 4);
      cnt_set <= n[15:0];
      cnt_en <= 1'b1;
      for (int k = 1; k <= n + 2; k++) begin
         cnt_in <= 1'b1;
         if (k <= n) exp_q.push_back(k[15:0]);
         scans(1);
         cnt_in <= 1'b0;
         scans(1);
      end
      chk("cnt_done_on", {15'h0000, cnt_done}, 16'h0001);
      gate <= 1'b0;
      scans(1);
      chk("rail_off", {15'h0000, cnt_done}, 16'h0000);
      chk("rail_off_tmr", {15'h0000, ofd_done[1]}, 16'h0000);
      gate <= 1'b1;
      scans(1);
      chk("rail_on", {15'h0000, cnt_done}, 16'h0001);
      chk("rail_on_tmr", {15'h0000, ofd_done[1]}, 16'h0001);
      cnt_en <= 1'b0;
      exp_q.push_back(16'h0000);
      scans(1);
      chk("cnt_done_off", {15'h0000, cnt_done}, 16'h0000);
      chk("cnt_queue_left", 16'(exp_q.size()), 16'h0000);
      $display("test counter finished");
      pulses = 0;
      edge_src <= 1'b1;
      scans(3);
      chk("edge_cycles", pulses[15:0], SCAN[15:0]);
      $display("test edge finished");
      end_of_test();
   end
endmodule
